/* p6pf_port.sv */
// Port 6 pin-function and pad-control logic with its AHB-Lite registers.
// Assumes peripheral enables and outputs arrive on mclk; pins are async.
`default_nettype none

module p6pf_port #(
	parameter int SYNC_STAGES = 2
) (
	// Clock, reset and enable.
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [p6pf_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Operating mode.
	input wire logic ext_mode,
	input wire logic bus_width_sel_16,
	input wire logic usb_enable,
	// Bus controller data path.
	input wire logic [7:0] bus_wr_data,
	input wire logic bus_drive,
	output logic [7:0] bus_rd_data,
	// Peripheral control bits.
	input wire logic kbd_comparator_enable,
	input wire logic [2:0] kbd_channel_sel,
	input wire logic [7:0] key_int_mask,
	input wire logic comp_blank_out_en,
	input wire logic timer_out_b_en,
	input wire logic clamp_out_en,
	input wire logic capture_b_int_en,
	input wire logic capture_c_int_en,
	input wire logic capture_d_int_en,
	input wire logic [1:0] sync_in_sel,
	// Peripheral output levels.
	input wire logic composite_blank_out,
	input wire logic timer_out_b,
	input wire logic clamp_out,
	input wire logic usb_tx_dpls,
	// Peripheral inputs taken from pins.
	output logic comparator_in,
	output logic [7:0] key_int_in,
	output logic timer_capture_b_in,
	output logic timer_capture_c_in,
	output logic timer_capture_d_in,
	output logic composite_sync_in,
	output logic vertical_feedback_in,
	output logic [2:0] usb_rx_in,
	// Pads.
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	output logic [7:0] pullup_on,
	output logic pullup_current_limit,
	output logic [1:0] input_level_sel
);
	import p6pf_pkg::*;

	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("p6pf_port needs at least two sync stages");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	p6pf_byte_t port_direction_reg;
	p6pf_byte_t port_output_latch_reg;
	p6pf_byte_t port_pullup_enable_reg;
	p6pf_byte_t input_level_pullup_config_reg;
	logic wr_pend_reg;
	logic [ADDR_W-1:0] wr_addr_reg;
	p6pf_byte_t pin_lvl;
	logic bus16_mode;
	logic usb_pins;
	p6pf_byte_t drive_next;
	p6pf_byte_t out_next;
	p6pf_byte_t read_port;
	logic [31:0] rdata_next;
	logic addr_ok;
	logic [31:0] hrdata_reg;

	p6pf_sync_if sif ();

	// Maps an address to a register slot; returns 4 when unmapped.
	function automatic logic [2:0] reg_slot(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_DIR: reg_slot = 3'h0;
			OFS_LATCH: reg_slot = 3'h1;
			OFS_PUE: reg_slot = 3'h2;
			OFS_CFG: reg_slot = 3'h3;
			default: reg_slot = 3'h4;
		endcase
	endfunction : reg_slot

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	assign sif.raw = pin_in;
	assign pin_lvl = sif.synced;

	p6pf_sync #(
		.STAGES(SYNC_STAGES)
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.sif(sif.syncer)
	);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// A USB enable keeps the port off the data bus; software should not
	// allow both, but the pins stay safe if it does.
	assign bus16_mode = ext_mode & bus_width_sel_16 & ~usb_enable;
	assign usb_pins = ~ext_mode & usb_enable;

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Per pin: general I/O first, then overrides from peripherals.
	always_comb begin
		drive_next = port_direction_reg;
		out_next = port_output_latch_reg;
		if (bus16_mode) begin
			drive_next = {8{bus_drive}};
			out_next = bus_wr_data;
		end else begin
			if (comp_blank_out_en) begin
				drive_next[PIN_BLANK] = 1'b1;
				out_next[PIN_BLANK] = composite_blank_out;
			end else if (timer_out_b_en) begin
				drive_next[PIN_BLANK] = 1'b1;
				out_next[PIN_BLANK] = timer_out_b;
			end
			if (clamp_out_en) begin
				drive_next[PIN_CLAMP] = 1'b1;
				out_next[PIN_CLAMP] = clamp_out;
			end
			if (usb_pins) begin
				// The transceiver owns these pins outright in single-chip.
				drive_next[7:PIN_USB_RX] = 3'h0;
				drive_next[PIN_USB_TX] = 1'b1;
				out_next[PIN_USB_TX] = usb_tx_dpls;
			end
		end
	end

	// Pad outputs, registered so they change only on mclk.
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_out <= 8'h00;
			pin_oe_n <= 8'hFF;
		end else if (ce) begin
			pin_out <= out_next;
			pin_oe_n <= ~drive_next;
		end
	end

	// ------------------------------------------------------------
	// Pad control
	// ------------------------------------------------------------
	// A pin only pulls up while it is not being driven, so the pull-up
	// never fights an output driver.
	always_ff @(posedge mclk) begin
		if (reset) begin
			pullup_on <= 8'h00;
			pullup_current_limit <= 1'b0;
			input_level_sel <= 2'h0;
		end else if (ce) begin
			if (bus16_mode) begin
				pullup_on <= 8'h00;
			end else begin
				pullup_on <= port_pullup_enable_reg & ~drive_next;
			end
			pullup_current_limit <=
				input_level_pullup_config_reg[CFG_ILIM];
			input_level_sel <= input_level_pullup_config_reg[
				CFG_LVL_HI:CFG_LVL_LO];
		end
	end

	// ------------------------------------------------------------
	// Peripheral inputs
	// ------------------------------------------------------------
	// Every enabled input sees the same sampled level in one cycle.
	always_ff @(posedge mclk) begin
		if (reset) begin
			comparator_in <= 1'b0;
			timer_capture_b_in <= 1'b0;
			timer_capture_c_in <= 1'b0;
			timer_capture_d_in <= 1'b0;
			composite_sync_in <= 1'b0;
			vertical_feedback_in <= 1'b0;
			usb_rx_in <= 3'h0;
		end else if (ce) begin
			comparator_in <= (kbd_comparator_enable & ~bus16_mode) ?
				pin_lvl[kbd_channel_sel] : 1'b0;
			timer_capture_b_in <= (capture_b_int_en & ~bus16_mode) ?
				pin_lvl[PIN_CAP_B] : 1'b0;
			timer_capture_c_in <= (capture_c_int_en & ~bus16_mode) ?
				pin_lvl[PIN_CLAMP] : 1'b0;
			timer_capture_d_in <= (capture_d_int_en & ~bus16_mode) ?
				pin_lvl[PIN_CAP_D] : 1'b0;
			composite_sync_in <=
				(sync_in_sel == SYNC_SEL_CSYNC && !bus16_mode) ?
				pin_lvl[PIN_CAP_D] : 1'b0;
			vertical_feedback_in <=
				(sync_in_sel == SYNC_SEL_VFB && !bus16_mode) ?
				pin_lvl[PIN_CAP_B] : 1'b0;
			usb_rx_in <= usb_pins ? pin_lvl[7:PIN_USB_RX] : 3'h0;
		end
	end

	// Key inputs idle high so a masked pin never looks like a key press.
	genvar g;
	for (g = 0; g < 8; g++) begin : g_key
		always_ff @(posedge mclk) begin
			if (reset) begin
				key_int_in[g] <= 1'b1;
			end else if (ce) begin
				key_int_in[g] <= (key_int_mask[g] | bus16_mode) ?
					1'b1 : pin_lvl[g];
			end
		end
	end

	// Bus controller reads the pins straight in data-bus mode.
	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_rd_data <= 8'h00;
		end else if (ce) begin
			bus_rd_data <= bus16_mode ? pin_lvl : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	// Port read merges latch and pin level per direction bit; in data-bus mode input bits read as one.
	always_comb begin
		if (bus16_mode) begin
			read_port = port_output_latch_reg | ~port_direction_reg;
		end else begin
			read_port = (port_output_latch_reg & port_direction_reg) |
				(pin_lvl & ~port_direction_reg);
		end
	end

	assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);

	// Read data is chosen in the address phase and shown next cycle.
	// The direction register is write-only and reads as zero.
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (reg_slot(haddr))
			3'h1: rdata_next[7:0] = read_port;
			3'h2: rdata_next[7:0] = port_pullup_enable_reg;
			3'h3: rdata_next[7:0] = input_level_pullup_config_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (ce && addr_ok && !hwrite) begin
			hrdata_reg <= rdata_next;
		end
	end
	assign hrdata = hrdata_reg;

	// Zero-wait slave: always ready, always OKAY.
	always_ff @(posedge mclk) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Write address is held over to the data phase.
	always_ff @(posedge mclk) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else if (ce && hready) begin
			wr_pend_reg <= addr_ok & hwrite & (hsize == HSIZE_WORD);
			wr_addr_reg <= haddr;
		end
	end

	// Register writes land in the data phase from the low byte.
	always_ff @(posedge mclk) begin
		if (reset) begin
			port_direction_reg <= RST_DIR;
			port_output_latch_reg <= RST_LATCH;
			port_pullup_enable_reg <= RST_PUE;
			input_level_pullup_config_reg <= RST_CFG;
		end else if (ce && wr_pend_reg) begin
			case (reg_slot(wr_addr_reg))
				3'h0: port_direction_reg <= hwdata[7:0];
				3'h1: port_output_latch_reg <= hwdata[7:0];
				3'h2: port_pullup_enable_reg <= hwdata[7:0];
				3'h3: input_level_pullup_config_reg <= hwdata[7:0];
				default: ;
			endcase
		end
	end

endmodule : p6pf_port

`default_nettype wire

/* p6pf_pkg.sv */
// Constants shared by the port 6 pin-function block: register map,
// field positions, reset values and mux codes.
// Assumes a 32-bit AHB-Lite register bus, one register per word.
`default_nettype none

package p6pf_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_DIR = 8'h00;
	localparam logic [7:0] OFS_LATCH = 8'h04;
	localparam logic [7:0] OFS_PUE = 8'h08;
	localparam logic [7:0] OFS_CFG = 8'h0C;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_PUE = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h00;

	// ------------------------------------------------------------
	// Configuration register fields
	// ------------------------------------------------------------
	localparam int CFG_LVL_HI = 7;
	localparam int CFG_LVL_LO = 6;
	localparam int CFG_ILIM = 5;

	// ------------------------------------------------------------
	// Pin positions of the dedicated functions
	// ------------------------------------------------------------
	localparam int PIN_BLANK = 6;
	localparam int PIN_CLAMP = 4;
	localparam int PIN_CAP_D = 5;
	localparam int PIN_CAP_B = 3;
	localparam int PIN_USB_TX = 4;
	localparam int PIN_USB_RX = 5;

	// ------------------------------------------------------------
	// Sync-input select codes
	// ------------------------------------------------------------
	localparam logic [1:0] SYNC_SEL_CSYNC = 2'h1;
	localparam logic [1:0] SYNC_SEL_VFB = 2'h0;

	// AHB transfer type and size codes.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef logic [7:0] p6pf_byte_t;

endpackage : p6pf_pkg

`default_nettype wire

/* p6pf_sync_if.sv */
// Interface carrying the raw pin levels to the synchroniser and the
// synchronised levels back to the port logic.
// Assumes both ends run on mclk.
`default_nettype none

interface p6pf_sync_if;
	logic [7:0] raw;
	logic [7:0] synced;

	// Port logic hands pins in and reads the safe copy.
	modport user (output raw, input synced);

	// Synchroniser reads pins and drives the safe copy.
	modport syncer (input raw, output synced);
endinterface : p6pf_sync_if

`default_nettype wire

/* p6pf_sync.sv */
// Multi-stage synchroniser for the eight pad input levels.
// Assumes pins are asynchronous to mclk; output valid after STAGES edges.
`default_nettype none

module p6pf_sync #(
	parameter int STAGES = 2
) (
	// Clock, reset and enable.
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	// Pin levels in, synchronised levels out.
	p6pf_sync_if.syncer sif
);
	import p6pf_pkg::*;

	// Fewer than two stages would not guard against metastability.
	if (STAGES < 2) begin : g_bad_stages
		$error("p6pf_sync needs at least two stages");
	end

	p6pf_byte_t stage_reg [STAGES];

	// ------------------------------------------------------------
	// Shift chain
	// ------------------------------------------------------------
	// Only the next stage reads each earlier stage.
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_reg[i] <= 8'h00;
			end
		end else if (ce) begin
			stage_reg[0] <= sif.raw;
			for (int i = 1; i < STAGES; i++) begin
				stage_reg[i] <= stage_reg[i - 1];
			end
		end
	end

	assign sif.synced = stage_reg[STAGES - 1];

endmodule : p6pf_sync

`default_nettype wire

/* p6pf_pad_model.sv */
// Pad model for the port 6 pins: block drive, outside drive, pull-up.
// Assumes one mclk domain; a pin that nobody holds toggles each cycle.
`default_nettype none

module p6pf_pad_model (
	// Clock.
	input wire logic mclk,
	// Block side of the pads.
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pullup_on,
	// Outside driver set by the bench.
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	// Resolved pad level.
	output logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt_reg = 8'h00;

	// A floating pin flips, so a missing pull-up cannot pass by luck.
	// A plain always keeps the declaration's start value legal.
	always @(posedge mclk) begin
		flt_reg <= ~flt_reg;
	end

	// Block drive wins, then the outside driver, then the pull-up.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pullup_on[i]) begin
				pin_in[i] = 1'h1;
			end else begin
				pin_in[i] = flt_reg[i];
			end
		end
	end
endmodule : p6pf_pad_model

`default_nettype wire

/* p6pf_checker.sv */
// Checker for the port 6 pin-function block, bound to its ports.
// Assumes one mclk domain and synchronous active-high reset.
`default_nettype none

module p6pf_checker #(
	parameter int SYNC_STAGES = 2
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Mode and controls.
	input wire logic ext_mode,
	input wire logic bus_width_sel_16,
	input wire logic usb_enable,
	input wire logic [7:0] bus_wr_data,
	input wire logic bus_drive,
	input wire logic [7:0] key_int_mask,
	input wire logic comp_blank_out_en,
	input wire logic timer_out_b_en,
	input wire logic clamp_out_en,
	input wire logic capture_d_int_en,
	input wire logic composite_blank_out,
	input wire logic timer_out_b,
	input wire logic clamp_out,
	// Results and pads.
	input wire logic timer_capture_d_in,
	input wire logic [7:0] key_int_in,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pullup_on
);
	import p6pf_pkg::*;
	logic bus16;
	logic fn;

	// Function mode excludes the wide bus and single-chip USB.
	assign bus16 = ext_mode & bus_width_sel_16 & ~usb_enable;
	assign fn = ~bus16 & (ext_mode | ~usb_enable);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	// Enable held long enough for a pin level to cross the synchroniser.
	sequence s_capd;
		(fn && capture_d_int_en)[*4];
	endsequence

	a_pullup_input_only: assert property (
		(pullup_on & ~pin_oe_n) == 8'h00)
		else $error("pull-up on a driven pin");
	a_wide_no_pullup: assert property (
		!$past(reset) && $past(bus16) |-> pullup_on == 8'h00)
		else $error("pull-up on in wide bus mode");
	a_wide_bus_drive: assert property (
		!$past(reset) && $past(bus16 && bus_drive) |->
		pin_oe_n == 8'h00 && pin_out == $past(bus_wr_data))
		else $error("wide bus byte not driven");
	a_wide_bus_release: assert property (
		!$past(reset) && $past(bus16 && !bus_drive) |->
		pin_oe_n == 8'hFF)
		else $error("wide bus not released");
	a_blank_on_pin6: assert property (
		!$past(reset) && $past(fn && comp_blank_out_en) |->
		!pin_oe_n[6] && pin_out[6] == $past(composite_blank_out))
		else $error("blanking not on pin 6");
	a_timer_b_pin6: assert property (
		!$past(reset) && $past(fn && !comp_blank_out_en &&
		timer_out_b_en) |->
		!pin_oe_n[6] && pin_out[6] == $past(timer_out_b))
		else $error("timer output not on pin 6");
	a_clamp_on_pin4: assert property (
		!$past(reset) && $past(fn && clamp_out_en) |->
		!pin_oe_n[4] && pin_out[4] == $past(clamp_out))
		else $error("clamp not on pin 4");
	a_key_masked_high: assert property (
		!$past(reset) |-> (~key_int_in & $past(key_int_mask)) == 8'h00)
		else $error("masked key input not high");
	a_capture_d_follow: assert property (
		s_capd |->
		timer_capture_d_in == $past(pin_in[5], SYNC_STAGES + 1))
		else $error("capture input does not follow pin 5");
endmodule : p6pf_checker

bind p6pf_port p6pf_checker #(.SYNC_STAGES(SYNC_STAGES)) u_p6pf_checker (
	.mclk, .reset, .ext_mode, .bus_width_sel_16, .usb_enable,
	.bus_wr_data, .bus_drive, .key_int_mask, .comp_blank_out_en,
	.timer_out_b_en, .clamp_out_en, .capture_d_int_en,
	.composite_blank_out, .timer_out_b, .clamp_out, .timer_capture_d_in,
	.key_int_in, .pin_in, .pin_out, .pin_oe_n, .pullup_on);

`default_nettype wire

/* tb.sv */
// Self-checking bench for the port 6 block, its pads and registers.
// Assumes the package, design, pad model and checker compile first.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import p6pf_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic mclk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0;
	logic [7:0] haddr = 8'h00, bus_wr_data = 8'h00, key_int_mask = 8'hFF;
	logic [1:0] htrans = 2'h0, sync_in_sel = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic ext_mode = 1'h0, bus_width_sel_16 = 1'h0, usb_enable = 1'h0;
	logic bus_drive = 1'h0, kbd_comparator_enable = 1'h0;
	logic [2:0] kbd_channel_sel = 3'h0, usb_rx_in;
	logic comp_blank_out_en = 1'h0, timer_out_b_en = 1'h0;
	logic clamp_out_en = 1'h0, capture_b_int_en = 1'h0;
	logic capture_c_int_en = 1'h0, capture_d_int_en = 1'h0;
	logic composite_blank_out = 1'h0, timer_out_b = 1'h0, clamp_out = 1'h0;
	logic usb_tx_dpls = 1'h0;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
	logic hreadyout, hresp, comparator_in, timer_capture_b_in;
	logic timer_capture_c_in, timer_capture_d_in, composite_sync_in;
	logic vertical_feedback_in, pullup_current_limit;
	logic [7:0] key_int_in, bus_rd_data, pin_in, pin_out, pin_oe_n;
	logic [7:0] pullup_on;
	logic [1:0] input_level_sel;
	int n_fail = 0, cmp_count = 0;

	// Free-running 200 MHz clock.
	always #2.5 mclk = ~mclk;

	p6pf_port u_p6pf_port (
		.mclk, .reset, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite,
		.hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .ext_mode, .bus_width_sel_16, .usb_enable,
		.bus_wr_data, .bus_drive, .bus_rd_data, .kbd_comparator_enable,
		.kbd_channel_sel, .key_int_mask, .comp_blank_out_en,
		.timer_out_b_en, .clamp_out_en, .capture_b_int_en,
		.capture_c_int_en, .capture_d_int_en, .sync_in_sel,
		.composite_blank_out, .timer_out_b, .clamp_out,
		.usb_tx_dpls, .comparator_in, .key_int_in,
		.timer_capture_b_in, .timer_capture_c_in, .timer_capture_d_in,
		.composite_sync_in, .vertical_feedback_in, .usb_rx_in, .pin_in,
		.pin_out, .pin_oe_n, .pullup_on, .pullup_current_limit,
		.input_level_sel);

	p6pf_pad_model u_p6pf_pad_model (
		.mclk, .pin_out, .pin_oe_n, .pullup_on, .ext_en, .ext_val,
		.pin_in);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Waits for hready at an edge; a stuck bus ends the run.
	task automatic wrdy();
		int k;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (hreadyout !== 1'h1 && k < 50);
		if (k >= 50) begin
			n_fail++;
			complete_run();
		end
	endtask : wrdy

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		wrdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wrdy();
		q = hrdata[7:0];
	endtask : bus

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] q;
		bus(1'h0, OFS_PUE, 8'h00, q);
		chk("pue", 8'h00, q);
		bus(1'h0, OFS_CFG, 8'h00, q);
		chk("cfg", 8'h00, q);
		chk("pull", 8'h00, pullup_on);
		bus(1'h0, 8'h40, 8'h00, q);
		chk("unmapped", 8'h00, q);
		chk("hresp", 8'h00, {7'h00, hresp});
	endtask : t_reset

	task automatic t_cfg();
		logic [7:0] q;
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = {i[1:0], i[0], 5'h00};
			bus(1'h1, OFS_CFG, v, q);
			tick(1);
			chk("level", {6'h00, i[1:0]}, {6'h00, input_level_sel});
			chk("ilim", {7'h00, i[0]}, {7'h00, pullup_current_limit});
			bus(1'h0, OFS_CFG, 8'h00, q);
			chk("cfg", v, q);
		end
	endtask : t_cfg

	task automatic t_gpio();
		logic [7:0] q;
		bus(1'h1, OFS_DIR, 8'h0F, q);
		bus(1'h1, OFS_LATCH, 8'hA5, q);
		bus(1'h1, OFS_PUE, 8'hFF, q);
		tick(3);
		chk("oe", 8'hF0, pin_oe_n);
		chk("out", 8'h05, pin_out & 8'h0F);
		chk("pull", 8'hF0, pullup_on);
		bus(1'h0, OFS_LATCH, 8'h00, q);
		chk("read", 8'hF5, q);
		@(posedge mclk);
		ext_en <= 8'hF0;
		key_int_mask <= 8'h0F;
		tick(3);
		chk("key", 8'h0F, key_int_in);
		bus(1'h0, OFS_LATCH, 8'h00, q);
		chk("read", 8'h05, q);
	endtask : t_gpio

	task automatic t_bus16();
		logic [7:0] q;
		@(posedge mclk);
		ext_mode <= 1'h1;
		bus_width_sel_16 <= 1'h1;
		bus_wr_data <= 8'h3C;
		ext_en <= 8'h00;
		tick(1);
		chk("oe", 8'hFF, pin_oe_n);
		chk("pull", 8'h00, pullup_on);
		@(posedge mclk);
		bus_drive <= 1'h1;
		tick(1);
		chk("oe", 8'h00, pin_oe_n);
		chk("out", 8'h3C, pin_out);
		bus(1'h0, OFS_LATCH, 8'h00, q);
		chk("read", 8'hF5, q);
		// The driven byte needs the synchroniser and one register to return.
		tick(3);
		chk("rd", 8'h3C, bus_rd_data);
		@(posedge mclk);
		usb_enable <= 1'h1;
		tick(1);
		chk("oe", 8'hF0, pin_oe_n);
		@(posedge mclk);
		usb_enable <= 1'h0;
		bus_width_sel_16 <= 1'h0;
		bus_drive <= 1'h0;
		tick(1);
		chk("oe", 8'hF0, pin_oe_n);
	endtask : t_bus16

	task automatic t_periph();
		logic [7:0] q;
		bus(1'h1, OFS_DIR, 8'h07, q);
		@(posedge mclk);
		comp_blank_out_en <= 1'h1;
		timer_out_b_en <= 1'h1;
		composite_blank_out <= 1'h1;
		clamp_out_en <= 1'h1;
		clamp_out <= 1'h1;
		tick(1);
		chk("pin64", 8'h50, pin_out & 8'h50);
		chk("oe", 8'hA8, pin_oe_n);
		@(posedge mclk);
		comp_blank_out_en <= 1'h0;
		tick(1);
		chk("pin6", 8'h00, pin_out & 8'h40);
		@(posedge mclk);
		timer_out_b_en <= 1'h0;
		clamp_out_en <= 1'h0;
		ext_en <= 8'hF8;
		kbd_comparator_enable <= 1'h1;
		tick(1);
		chk("oe", 8'hF8, pin_oe_n);
		// Of pins 7:3 only the selected one is high, so a wrong route among them reads low.
		for (int c = 3; c < 8; c++) begin
			@(posedge mclk);
			kbd_channel_sel <= c[2:0];
			ext_val <= 8'h01 << c;
			tick(3);
			chk("cmp", 8'h01, {7'h00, comparator_in});
		end
		@(posedge mclk);
		ext_val <= 8'h38;
		capture_b_int_en <= 1'h1;
		capture_c_int_en <= 1'h1;
		capture_d_int_en <= 1'h1;
		sync_in_sel <= SYNC_SEL_CSYNC;
		tick(3);
		chk("inputs", 8'h1E, {3'h0, timer_capture_d_in, timer_capture_c_in,
			timer_capture_b_in, composite_sync_in,
			vertical_feedback_in});
		@(posedge mclk);
		sync_in_sel <= SYNC_SEL_VFB;
		tick(3);
		chk("inputs", 8'h1D, {3'h0, timer_capture_d_in, timer_capture_c_in,
			timer_capture_b_in, composite_sync_in,
			vertical_feedback_in});
	endtask : t_periph

	// Single-chip with USB: pins 7:5 feed the receiver, pin 4 is driven.
	task automatic t_usb();
		@(posedge mclk);
		ext_mode <= 1'h0;
		usb_enable <= 1'h1;
		usb_tx_dpls <= 1'h1;
		ext_val <= 8'hA0;
		tick(3);
		chk("usb_oe", 8'hE8, pin_oe_n);
		chk("usb_tx", 8'h10, pin_out & 8'h10);
		chk("usb_rx", 8'h05, {5'h00, usb_rx_in});
	endtask : t_usb

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'h0;
		t_reset();
		t_cfg();
		t_gpio();
		t_bus16();
		t_periph();
		t_usb();
		complete_run();
	end
endmodule : tb

`default_nettype wire
